// [hdl/osf_map.svh]
// Register offsets, field positions, reset values and startup counts.
`ifndef OSF_MAP_SVH
`define OSF_MAP_SVH

`define OSF_SYNTH0_OFS   8'h20
`define OSF_SYNTH1_OFS   8'h24
`define OSF_OSC0_OFS     8'h28
`define OSF_OSC1_OFS     8'h2C
`define OSF_XTAL_OFS     8'h30
`define OSF_IER_OFS      8'h40
`define OSF_IDR_OFS      8'h44
`define OSF_IMR_OFS      8'h48
`define OSF_ISR_OFS      8'h4C
`define OSF_ICR_OFS      8'h50

`define OSF_RESET_VAL    32'h00000000
`define OSF_SYNTH_WMASK  32'hBF0F0F1F
`define OSF_OSC_WMASK    32'h00000707
`define OSF_XTAL_WMASK   32'h00070701

`define OSF_SY_TEST_BIT  31
`define OSF_SY_COUNT_LSB 24
`define OSF_SY_MUL_LSB   16
`define OSF_SY_DIV_LSB   8
`define OSF_SY_OPT_LSB   2
`define OSF_SY_SRC_BIT   1
`define OSF_SY_EN_BIT    0
`define OSF_OSC_ST_LSB   8
`define OSF_OSC_MODE_LSB 0
`define OSF_XT_ST_LSB    16
`define OSF_XT_MODE_LSB  8
`define OSF_XT_EN_BIT    0

`define OSF_IRQ_SYNTH0_LOCKED    0
`define OSF_IRQ_SYNTH1_LOCKED    1
`define OSF_IRQ_CLOCK_SWITCH_DONE    5
`define OSF_IRQ_GATING_DONE   6
`define OSF_IRQ_MAIN_OSC0_READY  7
`define OSF_IRQ_MAIN_OSC1_READY  8
`define OSF_IRQ_XTALRDY  9
`define OSF_IRQ_BOD      16
`define OSF_IRQ_BOD33    17
`define OSF_IRQ_IMPL     32'h000303E3
`define OSF_IRQ_STICKY   32'h000303C3

`define OSF_MODE_EXT     3'h0
`define OSF_MODE_XTAL    3'h4
`define OSF_XMODE_AGC    3'h1

`define OSF_MST_1 15'h0040
`define OSF_MST_2 15'h0080
`define OSF_MST_3 15'h0800
`define OSF_MST_4 15'h1000
`define OSF_MST_5 15'h2000
`define OSF_MST_6 15'h4000
`define OSF_XST_1 20'h00080
`define OSF_XST_2 20'h02000
`define OSF_XST_3 20'h04000
`define OSF_XST_4 20'h10000
`define OSF_XST_5 20'h20000
`define OSF_XST_6 20'h40000
`define OSF_XST_7 20'h80000

`endif

// [hdl/osf_pkg.sv]
// Types shared by the oscillator and synthesizer control block.
package osf_pkg;
  typedef logic [31:0] osf_word_t;
  typedef logic [5:0]  osf_count_t;
  typedef logic [3:0]  osf_ratio_t;
  typedef logic [1:0]  osf_gain_t;
  typedef enum logic [1:0] {OSF_OFF, OSF_WAIT, OSF_LOCKED} osf_lock_st_t;
endpackage : osf_pkg

// [hdl/osf_lock_timer.sv]
// Lock wait timer for one frequency synthesizer.
`timescale 1ns/10ps
module osf_lock_timer (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Control
  input  wire logic               enable,
  input  wire logic               restart,
  input  wire logic               slow_tick,
  input  wire osf_pkg::osf_count_t wait_count,
  // Status
  output logic                    locked
);
  import osf_pkg::*;

  osf_lock_st_t st_q;
  osf_lock_st_t st_d;
  osf_count_t   cnt_q;
  osf_count_t   cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      OSF_OFF: begin
        if (enable) begin
          st_d  = OSF_WAIT;
          cnt_d = wait_count;
        end
      end
      OSF_WAIT: begin
        if (cnt_q == 6'h00) begin
          st_d = OSF_LOCKED; // [RULE1]
        end else if (slow_tick) begin
          cnt_d = cnt_q - 6'h01; // [RULE1]
        end
      end
      OSF_LOCKED: st_d = OSF_LOCKED;
      default: st_d = OSF_OFF;
    endcase
    // A register write or a wake from sleep starts the wait again.
    if (restart && enable) begin
      st_d  = OSF_WAIT; // [RULE1]
      cnt_d = wait_count;
    end
    if (!enable) begin
      st_d = OSF_OFF; // [RULE7]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= OSF_OFF;
      cnt_q <= 6'h00;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign locked = (st_q == OSF_LOCKED);
endmodule : osf_lock_timer

// [hdl/osf_ctrl.sv]
// Oscillator, frequency synthesizer and interrupt control registers.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "osf_map.svh"

// Behaviour
// RULE1: Lock flag after programmed slow-clock wait count.
// RULE2: Software writes zero to synthesizer test bit.
// RULE3: Multiply and divide fields set frequency ratio.
// RULE4: Option bit 0 selects VCO range.
// RULE5: Option bit 1 halves output frequency.
// RULE6: Option bit 2 one disables wide bandwidth.
// RULE7: Source bit picks oscillator; enable bit runs.
// RULE8: Main startup code maps to RC cycles.
// RULE9: Main mode selects external clock or crystal gain.
// RULE10: Slow startup code maps to RC cycles.
// RULE11: Slow oscillator register cleared by power-on only.
// RULE12: Slow mode selects external clock or AGC crystal.
// RULE13: Slow enable bit runs the 32 kHz oscillator.
// RULE14: Enable-set writes of one set mask bits.
// RULE15: Enable-clear writes of one clear mask bits.
// RULE16: Mask one enables; shared interrupt bit layout.
// RULE17: IO brown-out flag set on rising detection.
// RULE18: Core brown-out flag set on rising detection.
// RULE19: Flag-clear writes of one clear flags.
// RULE20: Lock flags set on rising live lock.
// RULE21: Interrupt output when flag and mask set.
module osf_ctrl #(
  parameter int ADDR_W = 8
) (
  // Clock and resets
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                por_n,
  // Register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire osf_pkg::osf_word_t  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output osf_pkg::osf_word_t       reg_rdata,
  // Slow clock, wake and live status inputs
  input  wire logic                rc_system_clock,
  input  wire logic [1:0]          synth_wake,
  input  wire logic                clock_switch_done,
  input  wire logic                gating_done,
  input  wire logic                main_osc0_ready,
  input  wire logic                main_osc1_ready,
  input  wire logic                slow_xtal_ready,
  input  wire logic                core_brownout_flag,
  input  wire logic                io_brownout_flag,
  // Synthesizer controls
  output logic [1:0]               synth_enable_bit,
  output logic [1:0]               synth_source_select,
  output osf_pkg::osf_ratio_t      synth0_multiply,
  output osf_pkg::osf_ratio_t      synth0_divide,
  output osf_pkg::osf_ratio_t      synth1_multiply,
  output osf_pkg::osf_ratio_t      synth1_divide,
  output logic [1:0]               synth_vco_low_range,
  output logic [1:0]               synth_out_half,
  output logic [1:0]               synth_wide_bw_en,
  output logic [1:0]               synth_locked,
  // Main oscillator controls
  output logic [1:0]               main_osc_ext_clock,
  output logic [1:0]               main_osc_crystal,
  output osf_pkg::osf_gain_t       main_osc0_gain,
  output osf_pkg::osf_gain_t       main_osc1_gain,
  output logic [14:0]              main_osc0_startup_cycles,
  output logic [14:0]              main_osc1_startup_cycles,
  // Slow crystal controls
  output logic                     slow_xtal_enable,
  output logic                     slow_xtal_ext_clock,
  output logic                     slow_xtal_agc,
  output logic [19:0]              slow_xtal_startup_cycles,
  // Interrupt request
  output logic                     irq
);
  import osf_pkg::*;

  function automatic logic [14:0] main_startup(input logic [2:0] code);
    case (code)
      3'h1:    main_startup = `OSF_MST_1;
      3'h2:    main_startup = `OSF_MST_2;
      3'h3:    main_startup = `OSF_MST_3;
      3'h4:    main_startup = `OSF_MST_4;
      3'h5:    main_startup = `OSF_MST_5;
      3'h6:    main_startup = `OSF_MST_6;
      default: main_startup = 15'h0000;
    endcase
  endfunction : main_startup

  function automatic logic [19:0] xtal_startup(input logic [2:0] code);
    case (code)
      3'h1:    xtal_startup = `OSF_XST_1;
      3'h2:    xtal_startup = `OSF_XST_2;
      3'h3:    xtal_startup = `OSF_XST_3;
      3'h4:    xtal_startup = `OSF_XST_4;
      3'h5:    xtal_startup = `OSF_XST_5;
      3'h6:    xtal_startup = `OSF_XST_6;
      3'h7:    xtal_startup = `OSF_XST_7;
      default: xtal_startup = 20'h00000;
    endcase
  endfunction : xtal_startup

  function automatic logic [2:0] osc_mode(input osf_word_t r);
    osc_mode = r[`OSF_OSC_MODE_LSB +: 3];
  endfunction : osc_mode

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  osf_word_t synth0_q;
  osf_word_t synth1_q;
  osf_word_t osc0_q;
  osf_word_t osc1_q;
  osf_word_t xtal_q;
  osf_word_t mask_q;
  osf_word_t mask_d;
  osf_word_t flag_q;
  osf_word_t flag_d;
  osf_word_t live_q;
  osf_word_t rdata_q;
  osf_word_t rdata_d;

  // Decode of the register port.
  wire wr_synth0 = reg_wr && hit(reg_addr, `OSF_SYNTH0_OFS);
  wire wr_synth1 = reg_wr && hit(reg_addr, `OSF_SYNTH1_OFS);
  wire wr_osc0   = reg_wr && hit(reg_addr, `OSF_OSC0_OFS);
  wire wr_osc1   = reg_wr && hit(reg_addr, `OSF_OSC1_OFS);
  wire wr_xtal   = reg_wr && hit(reg_addr, `OSF_XTAL_OFS);
  wire wr_ier    = reg_wr && hit(reg_addr, `OSF_IER_OFS);
  wire wr_idr    = reg_wr && hit(reg_addr, `OSF_IDR_OFS);
  wire wr_icr    = reg_wr && hit(reg_addr, `OSF_ICR_OFS);

  // Three-stage synchronisers for the asynchronous status pins.
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] lvl_q;
  wire  [7:0] pins = {io_brownout_flag, core_brownout_flag, slow_xtal_ready,
                      main_osc1_ready, main_osc0_ready, gating_done,
                      clock_switch_done, rc_system_clock};
  // A level only moves once the second and third stages agree.
  wire  [7:0] lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  wire        slow_tick = lvl_d[0] & ~lvl_q[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 8'h00;
      s2_q  <= 8'h00;
      s3_q  <= 8'h00;
      lvl_q <= 8'h00;
    end else begin
      s1_q  <= pins;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Lock wait timers, one per synthesizer.
  logic [1:0] lock_live;
  // A rewrite restarts on the edge it lands, so it must load the new count.
  wire osf_count_t cnt0_w = wr_synth0 ? reg_wdata[`OSF_SY_COUNT_LSB +: 6]
                                      : synth0_q[`OSF_SY_COUNT_LSB +: 6];
  wire osf_count_t cnt1_w = wr_synth1 ? reg_wdata[`OSF_SY_COUNT_LSB +: 6]
                                      : synth1_q[`OSF_SY_COUNT_LSB +: 6];

  osf_lock_timer u_synth0_locked (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (synth0_q[`OSF_SY_EN_BIT]),
    .restart    (wr_synth0 | synth_wake[0]),
    .slow_tick  (slow_tick),
    .wait_count (cnt0_w), // [RULE1]
    .locked     (lock_live[0])
  );

  osf_lock_timer u_synth1_locked (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (synth1_q[`OSF_SY_EN_BIT]),
    .restart    (wr_synth1 | synth_wake[1]),
    .slow_tick  (slow_tick),
    .wait_count (cnt1_w), // [RULE1]
    .locked     (lock_live[1])
  );

  // Live status word in the shared interrupt layout.
  osf_word_t live_w;
  always_comb begin
    live_w                   = 32'h00000000;
    live_w[`OSF_IRQ_SYNTH0_LOCKED]   = lock_live[0];
    live_w[`OSF_IRQ_SYNTH1_LOCKED]   = lock_live[1];
    live_w[`OSF_IRQ_CLOCK_SWITCH_DONE]   = lvl_q[1];
    live_w[`OSF_IRQ_GATING_DONE]  = lvl_q[2];
    live_w[`OSF_IRQ_MAIN_OSC0_READY] = lvl_q[3];
    live_w[`OSF_IRQ_MAIN_OSC1_READY] = lvl_q[4];
    live_w[`OSF_IRQ_XTALRDY] = lvl_q[5];
    live_w[`OSF_IRQ_BOD]     = lvl_q[6];
    live_w[`OSF_IRQ_BOD33]   = lvl_q[7];
  end

  wire osf_word_t rise_w = live_w & ~live_q & `OSF_IRQ_STICKY; // [RULE17] [RULE18] [RULE20]
  wire osf_word_t clr_w  = wr_icr ? reg_wdata : 32'h00000000;  // [RULE19]

  // A rising event in the same cycle as its clear keeps the flag set.
  assign flag_d = ((flag_q & ~clr_w) | rise_w) & `OSF_IRQ_STICKY; // [RULE19]

  always_comb begin
    mask_d = mask_q;
    if (wr_ier) begin
      mask_d = mask_q | (reg_wdata & `OSF_IRQ_IMPL); // [RULE14]
    end
    if (wr_idr) begin
      mask_d = mask_q & ~reg_wdata; // [RULE15]
    end
  end

  // Clock-switch-done is a plain level in the status view, not a sticky flag.
  wire osf_word_t isr_view = flag_q | (live_w & ~`OSF_IRQ_STICKY & `OSF_IRQ_IMPL);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= `OSF_RESET_VAL;
      flag_q <= `OSF_RESET_VAL;
      live_q <= `OSF_RESET_VAL;
    end else begin
      mask_q <= mask_d;
      flag_q <= flag_d;
      live_q <= live_w;
    end
  end

  // Synthesizer and main oscillator registers follow the system reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synth0_q <= `OSF_RESET_VAL;
      synth1_q <= `OSF_RESET_VAL;
      osc0_q   <= `OSF_RESET_VAL;
      osc1_q   <= `OSF_RESET_VAL;
    end else begin
      if (wr_synth0) synth0_q <= reg_wdata & `OSF_SYNTH_WMASK;
      if (wr_synth1) synth1_q <= reg_wdata & `OSF_SYNTH_WMASK;
      if (wr_osc0)   osc0_q   <= reg_wdata & `OSF_OSC_WMASK;
      if (wr_osc1)   osc1_q   <= reg_wdata & `OSF_OSC_WMASK;
    end
  end

  // The slow crystal keeps running through system resets, so its
  // control register only returns to zero on power-on.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      xtal_q <= `OSF_RESET_VAL; // [RULE11]
    end else if (wr_xtal) begin
      xtal_q <= reg_wdata & `OSF_XTAL_WMASK;
    end
  end

  // Read multiplexer; write-only and unmapped addresses read zero.
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      if (hit(reg_addr, `OSF_SYNTH0_OFS)) rdata_d = synth0_q;
      if (hit(reg_addr, `OSF_SYNTH1_OFS)) rdata_d = synth1_q;
      if (hit(reg_addr, `OSF_OSC0_OFS))   rdata_d = osc0_q;
      if (hit(reg_addr, `OSF_OSC1_OFS))   rdata_d = osc1_q;
      if (hit(reg_addr, `OSF_XTAL_OFS))   rdata_d = xtal_q;
      if (hit(reg_addr, `OSF_IMR_OFS))    rdata_d = mask_q; // [RULE16]
      if (hit(reg_addr, `OSF_ISR_OFS))    rdata_d = isr_view;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `OSF_RESET_VAL;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Registered control outputs for the analog oscillators and synthesizers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_enable_bit    <= 2'h0;
      synth_source_select <= 2'h0;
      synth0_multiply     <= 4'h0;
      synth0_divide       <= 4'h0;
      synth1_multiply     <= 4'h0;
      synth1_divide       <= 4'h0;
      synth_vco_low_range <= 2'h0;
      synth_out_half      <= 2'h0;
      synth_wide_bw_en    <= 2'h3;
    end else begin
      synth_enable_bit    <= {synth1_q[`OSF_SY_EN_BIT], synth0_q[`OSF_SY_EN_BIT]};   // [RULE7]
      synth_source_select <= {synth1_q[`OSF_SY_SRC_BIT], synth0_q[`OSF_SY_SRC_BIT]}; // [RULE7]
      synth0_multiply     <= synth0_q[`OSF_SY_MUL_LSB +: 4]; // [RULE3]
      synth0_divide       <= synth0_q[`OSF_SY_DIV_LSB +: 4]; // [RULE3]
      synth1_multiply     <= synth1_q[`OSF_SY_MUL_LSB +: 4]; // [RULE3]
      synth1_divide       <= synth1_q[`OSF_SY_DIV_LSB +: 4]; // [RULE3]
      synth_vco_low_range <= {synth1_q[`OSF_SY_OPT_LSB], synth0_q[`OSF_SY_OPT_LSB]};       // [RULE4]
      synth_out_half      <= {synth1_q[`OSF_SY_OPT_LSB+1], synth0_q[`OSF_SY_OPT_LSB+1]};   // [RULE5]
      synth_wide_bw_en    <= ~{synth1_q[`OSF_SY_OPT_LSB+2], synth0_q[`OSF_SY_OPT_LSB+2]};  // [RULE6]
    end
  end

  wire [2:0] m0 = osc_mode(osc0_q);
  wire [2:0] m1 = osc_mode(osc1_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_osc_ext_clock       <= 2'h3;
      main_osc_crystal         <= 2'h0;
      main_osc0_gain           <= 2'h0;
      main_osc1_gain           <= 2'h0;
      main_osc0_startup_cycles <= 15'h0000;
      main_osc1_startup_cycles <= 15'h0000;
    end else begin
      // Reserved modes 1 to 3 select neither source.
      main_osc_ext_clock <= {m1 == `OSF_MODE_EXT, m0 == `OSF_MODE_EXT}; // [RULE9]
      main_osc_crystal   <= {m1 >= `OSF_MODE_XTAL, m0 >= `OSF_MODE_XTAL}; // [RULE9]
      main_osc0_gain     <= m0[1:0]; // [RULE9]
      main_osc1_gain     <= m1[1:0]; // [RULE9]
      main_osc0_startup_cycles <= main_startup(osc0_q[`OSF_OSC_ST_LSB +: 3]); // [RULE8]
      main_osc1_startup_cycles <= main_startup(osc1_q[`OSF_OSC_ST_LSB +: 3]); // [RULE8]
    end
  end

  wire [2:0] xm = xtal_q[`OSF_XT_MODE_LSB +: 3];

  // Slow crystal outputs share the power-on reset with their register.
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      slow_xtal_enable         <= 1'b0;
      slow_xtal_ext_clock      <= 1'b1;
      slow_xtal_agc            <= 1'b0;
      slow_xtal_startup_cycles <= 20'h00000;
    end else begin
      slow_xtal_enable         <= xtal_q[`OSF_XT_EN_BIT]; // [RULE13]
      slow_xtal_ext_clock      <= (xm == `OSF_MODE_EXT);  // [RULE12]
      slow_xtal_agc            <= (xm == `OSF_XMODE_AGC); // [RULE12]
      slow_xtal_startup_cycles <= xtal_startup(xtal_q[`OSF_XT_ST_LSB +: 3]); // [RULE10]
    end
  end

  assign synth_locked = lock_live;
  assign irq          = |(isr_view & mask_q); // [RULE21]
endmodule : osf_ctrl

// [verif/osf_ctrl_properties.sv]
// Port-level assertions for the oscillator and synthesizer control block.
`timescale 1ns/10ps
module osf_ctrl_properties #(
  parameter int ADDR_W = 8
) (
  // Clock and resets
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                por_n,
  // Register port
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire osf_pkg::osf_word_t  reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire osf_pkg::osf_word_t  reg_rdata,
  // Decoded controls
  input wire logic [1:0]          synth_enable_bit,
  input wire logic [1:0]          synth_source_select,
  input wire osf_pkg::osf_ratio_t synth0_multiply,
  input wire osf_pkg::osf_ratio_t synth0_divide,
  input wire osf_pkg::osf_ratio_t synth1_multiply,
  input wire osf_pkg::osf_ratio_t synth1_divide,
  input wire logic [1:0]          synth_vco_low_range,
  input wire logic [1:0]          synth_out_half,
  input wire logic [1:0]          synth_wide_bw_en,
  input wire logic [1:0]          synth_locked,
  input wire logic [1:0]          main_osc_ext_clock,
  input wire logic [1:0]          main_osc_crystal,
  input wire osf_pkg::osf_gain_t  main_osc0_gain,
  input wire logic [14:0]         main_osc0_startup_cycles,
  input wire osf_pkg::osf_gain_t  main_osc1_gain,
  input wire logic [14:0]         main_osc1_startup_cycles,
  input wire logic                slow_xtal_enable,
  input wire logic                slow_xtal_ext_clock,
  input wire logic                slow_xtal_agc,
  input wire logic [19:0]         slow_xtal_startup_cycles,
  // Interrupt request
  input wire logic                irq
);
  import osf_pkg::*;
  localparam logic [14:0] MST [8] = '{15'h0000, 15'h0040, 15'h0080, 15'h0800, 15'h1000,
                                      15'h2000, 15'h4000, 15'h0000};
  localparam logic [19:0] XST [8] = '{20'h00000, 20'h00080, 20'h02000, 20'h04000,
                                      20'h10000, 20'h20000, 20'h40000, 20'h80000};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A quiet cycle after the write, so the decode two edges on belongs to it.
  sequence s_wr(a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  AST_WO_READ_ZERO: assert property (reg_rd && reg_addr inside {8'h40, 8'h44, 8'h50}
    |=> reg_rdata == '0) else $error("write-only register read back non-zero");
  AST_SYNTH0_RATIO: assert property (s_wr(8'h20) |=> synth0_multiply == $past(reg_wdata[19:16], 2)
    && synth0_divide == $past(reg_wdata[11:8], 2)) else $error("ratio fields not decoded");
  AST_SYNTH0_OPTS: assert property (s_wr(8'h20) |=> synth_vco_low_range[0] == $past(reg_wdata[2], 2)
    && synth_out_half[0] == $past(reg_wdata[3], 2) && synth_wide_bw_en[0] == !$past(reg_wdata[4], 2))
    else $error("option bits not decoded");
  AST_SYNTH0_SRC_EN: assert property (s_wr(8'h20) |=> synth_enable_bit[0] == $past(reg_wdata[0], 2)
    && synth_source_select[0] == $past(reg_wdata[1], 2)) else $error("enable or source wrong");
  AST_MAIN_STARTUP: assert property (s_wr(8'h28)
    |=> main_osc0_startup_cycles == MST[$past(reg_wdata[10:8], 2)]) else $error("startup count wrong");
  AST_MAIN_MODE: assert property (s_wr(8'h28) |=> main_osc_ext_clock[0] == ($past(reg_wdata[2:0], 2) == 3'h0)
    && main_osc_crystal[0] == $past(reg_wdata[2], 2) && main_osc0_gain == $past(reg_wdata[1:0], 2))
    else $error("main mode decode wrong");
  AST_XTAL_DECODE: assert property (disable iff (!rst_n || !por_n) s_wr(8'h30)
    |=> slow_xtal_startup_cycles == XST[$past(reg_wdata[18:16], 2)] && slow_xtal_enable == $past(reg_wdata[0], 2)
    && slow_xtal_agc == ($past(reg_wdata[10:8], 2) == 3'h1)
    && slow_xtal_ext_clock == ($past(reg_wdata[10:8], 2) == 3'h0))
    else $error("slow crystal decode wrong");
  AST_LOCK_DROP: assert property (reg_wr && reg_addr == 8'h20 && !reg_wdata[0]
    |=> !synth_locked[0]) else $error("lock held after disable");
  AST_LOCK_WAIT: assert property (reg_wr && reg_addr == 8'h20 && reg_wdata[0] && reg_wdata[29:24] > 6'd1
    |=> !synth_locked[0] [*2]) else $error("lock before wait count");
  AST_IRQ_OFF: assert property (reg_wr && reg_addr == 8'h44 && reg_wdata == 32'hFFFFFFFF
    |=> !irq) else $error("interrupt with all masks cleared");
  AST_SYNTH1_DECODE: assert property (s_wr(8'h24)
    |=> synth1_multiply == $past(reg_wdata[19:16], 2)
    && synth1_divide == $past(reg_wdata[11:8], 2)
    && synth_enable_bit[1] == $past(reg_wdata[0], 2)
    && synth_wide_bw_en[1] == !$past(reg_wdata[4], 2))
    else $error("second synthesizer decode wrong");
  AST_MAIN1_DECODE: assert property (s_wr(8'h2C)
    |=> main_osc1_gain == $past(reg_wdata[1:0], 2)
    && main_osc1_startup_cycles == MST[$past(reg_wdata[10:8], 2)])
    else $error("second main oscillator decode wrong");
endmodule : osf_ctrl_properties

// [verif/tb_osf_ctrl.sv]
// Self-checking bench for the oscillator and synthesizer control block.
`timescale 1ns/10ps
`include "osf_map.svh"
module tb_osf_ctrl;
  import osf_pkg::*;
  logic       clk;
  logic       rst_n;
  logic       por_n;
  logic [7:0] reg_addr;
  osf_word_t  reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  osf_word_t  reg_rdata;
  logic       rc_clk;
  logic [1:0] wake;
  logic [6:0] live;
  logic [1:0] locked;
  logic       irq;
  logic       irq_s;
  osf_word_t  mask;
  osf_word_t  d;
  osf_word_t  b;
  int         failures;
  int         total_checks;
  int         n;
  int         pos [7] = '{5, 6, 7, 8, 9, 16, 17};
  logic [7:0] ofs [11] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h40, 8'h44, 8'h48, 8'h4C,
                           8'h50, 8'h3C};

  osf_ctrl osf_ctrl_i (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_system_clock(rc_clk),
    .synth_wake(wake), .clock_switch_done(live[0]), .gating_done(live[1]),
    .main_osc0_ready(live[2]), .main_osc1_ready(live[3]), .slow_xtal_ready(live[4]),
    .core_brownout_flag(live[5]), .io_brownout_flag(live[6]), .synth_enable_bit(),
    .synth_source_select(), .synth0_multiply(), .synth0_divide(), .synth1_multiply(),
    .synth1_divide(), .synth_vco_low_range(), .synth_out_half(), .synth_wide_bw_en(),
    .synth_locked(locked), .main_osc_ext_clock(), .main_osc_crystal(), .main_osc0_gain(),
    .main_osc1_gain(), .main_osc0_startup_cycles(), .main_osc1_startup_cycles(),
    .slow_xtal_enable(), .slow_xtal_ext_clock(), .slow_xtal_agc(),
    .slow_xtal_startup_cycles(), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Slow clock period is 23 clk periods, so its edges land alternately on clk rising and clk falling edges.
  initial begin
    rc_clk = 1'b0;
    forever #230 rc_clk = ~rc_clk;
  end

  task automatic complete_run();
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input osf_word_t got, input osf_word_t exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input osf_word_t v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input osf_word_t exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    irq_s = irq;
    @(posedge clk);
  endtask : rdc

  task automatic wait_lock(input int s);
    n = 0;
    while (locked[s] !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 2000) begin
      failures++;
      complete_run();
    end
  endtask : wait_lock

  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    wake = 2'b00;
    live = '0;
    failures = 0;
    total_checks = 0;
    void'($urandom(89));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) rdc(ofs[i], '0);
    for (int k = 0; k < 16; k++) begin
      d = {1'b0, 31'($urandom)};
      wr(k[0] ? `OSF_SYNTH1_OFS : `OSF_SYNTH0_OFS, d);
      rdc(k[0] ? `OSF_SYNTH1_OFS : `OSF_SYNTH0_OFS, d & `OSF_SYNTH_WMASK);
    end
    for (int k = 0; k < 64; k++) wr(`OSF_OSC0_OFS, {21'h0, k[5:3], 5'h0, k[2:0]});
    d = $urandom;
    wr(`OSF_OSC1_OFS, d);
    rdc(`OSF_OSC1_OFS, d & `OSF_OSC_WMASK);
    for (int k = 0; k < 16; k++) wr(`OSF_XTAL_OFS, {13'h0, k[2:0], 7'h0, k[3], 7'h0, k[0]});
    d = $urandom;
    wr(`OSF_XTAL_OFS, d);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(`OSF_XTAL_OFS, d & `OSF_XTAL_WMASK);
    rdc(`OSF_SYNTH0_OFS, '0);
    mask = '0;
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      wr(k[0] ? `OSF_IDR_OFS : `OSF_IER_OFS, d);
      mask = k[0] ? mask & ~d : mask | d;
      rdc(`OSF_IMR_OFS, mask & `OSF_IRQ_IMPL);
    end
    wr(`OSF_IER_OFS, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) begin
      b = 32'h1 << pos[i];
      if (i == 6) wr(`OSF_IDR_OFS, b);
      live[i] <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(`OSF_ISR_OFS, b);
      chk(32'(irq_s), 32'(i != 6));
      live[i] <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(`OSF_ISR_OFS, i == 0 ? '0 : b);
      wr(`OSF_ICR_OFS, ~b);
      rdc(`OSF_ISR_OFS, i == 0 ? '0 : b);
      wr(`OSF_ICR_OFS, b);
      rdc(`OSF_ISR_OFS, '0);
      chk(32'(irq_s), 32'h0);
    end
    for (int s = 0; s < 2; s++) begin
      b = 32'h1 << s;
      wr(`OSF_IER_OFS, b);
      wr(s ? `OSF_SYNTH1_OFS : `OSF_SYNTH0_OFS, 32'h04000001);
      wait_lock(s);
      chk(32'(n >= 60), 32'h1);
      @(posedge clk);
      rdc(`OSF_ISR_OFS, b);
      chk(32'(irq_s), 32'h1);
      wr(`OSF_ICR_OFS, b);
      wake[s] <= 1'b1;
      @(posedge clk);
      wake[s] <= 1'b0;
      repeat (2) @(posedge clk);
      wait_lock(s);
      chk(32'(n >= 55), 32'h1);
      @(posedge clk);
      rdc(`OSF_ISR_OFS, b);
      wr(`OSF_IDR_OFS, 32'hFFFFFFFF);
      wr(s ? `OSF_SYNTH1_OFS : `OSF_SYNTH0_OFS, 32'h0);
      wr(`OSF_ICR_OFS, b);
    end
    por_n <= 1'b0;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    @(posedge clk);
    rdc(`OSF_XTAL_OFS, '0);
    complete_run();
  end
endmodule : tb_osf_ctrl

bind osf_ctrl osf_ctrl_properties #(.ADDR_W(ADDR_W)) osf_ctrl_properties_i (
  .clk, .rst_n, .por_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .synth_enable_bit,
  .synth_source_select, .synth0_multiply, .synth0_divide, .synth1_multiply, .synth1_divide,
  .synth_vco_low_range, .synth_out_half, .synth_wide_bw_en, .synth_locked, .main_osc_ext_clock,
  .main_osc_crystal, .main_osc0_gain, .main_osc1_gain, .main_osc0_startup_cycles,
  .main_osc1_startup_cycles, .slow_xtal_enable, .slow_xtal_ext_clock, .slow_xtal_agc,
  .slow_xtal_startup_cycles, .irq
);
